// >>> hw/ict_pkg.sv
// constants shared by the interval carry timer design
// ==========================================================================
// Behaviour
// - carry flag sets periodically every 100, 50, 20 or 10 ms by select field
// - first carry read after power-on reset always returns zero; the design returns one after an earlier clock stop or backup reset
// - after power-on, flag never sets until one carry read has executed; the design sets it on clock stop or backup reset before that
// - backup pin high applies backup reset at the next carry setting moment
// - reading the carry flag returns its value and clears it
// - flag is 0 after power-on, 1 after backup reset or clock stop
// - interval pulses come from dividing the system clock
// - four setting pulses 10, 20, 50, 100 Hz; select field picks one
// - pulses run continuously; changing selection restarts no divider
// - on selection change a rising new pulse sets the flag, falling does not; the design sets it whenever the old pulse was low and the new one is high
// - phase offsets between pulses stay shorter than the new pulse period
// - select code 00 picks the 10 Hz pulse, a 100 ms interval
// - carry register shows the flag at bit 0, other bits read zero
// - a carry read coinciding with pending backup reset wins; reset deferred
package ict_pkg;
    // ======================================================================
    // timing
    localparam int unsigned SYS_CLK_HZ = 10_000_000;
    localparam int unsigned TSET_10HZ_MS = 100;
    localparam int unsigned TSET_20HZ_MS = 50;
    localparam int unsigned TSET_50HZ_MS = 20;
    localparam int unsigned TSET_100HZ_MS = 10;
    localparam int unsigned CYC_PER_MS = SYS_CLK_HZ / 1000;
    localparam int unsigned PER_10HZ = TSET_10HZ_MS * CYC_PER_MS;
    localparam int unsigned PER_20HZ = TSET_20HZ_MS * CYC_PER_MS;
    localparam int unsigned PER_50HZ = TSET_50HZ_MS * CYC_PER_MS;
    localparam int unsigned PER_100HZ = TSET_100HZ_MS * CYC_PER_MS;
    localparam int unsigned NUM_PULSES = 4;
    // ======================================================================
    // register map (printed offsets are indices, byte address is 4x)
    localparam logic [7:0] REG_CARRY_IDX = 8'h17;
    localparam logic [7:0] REG_SELECT_IDX = 8'h18;
    localparam logic [9:0] ADDR_CARRY = {REG_CARRY_IDX, 2'b00};
    localparam logic [9:0] ADDR_SELECT = {REG_SELECT_IDX, 2'b00};
    localparam int unsigned CARRY_BIT = 0;
    localparam int unsigned INTERVAL_SELECT_LO = 0;
    localparam int unsigned INTERVAL_SELECT_HI = 1;
    localparam logic [1:0] SELECT_RESET = 2'b00;
    localparam logic [1:0] SEL_10HZ = 2'b00;
    localparam logic [1:0] SEL_20HZ = 2'b01;
    localparam logic [1:0] SEL_50HZ = 2'b10;
    localparam logic [1:0] SEL_100HZ = 2'b11;
    // ======================================================================
    // bus
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] HSIZE_WORD = 3'b010;
    localparam logic HRESP_OKAY = 1'b0;
endpackage

// >>> hw/ict_div_if.sv
// carrier for the four running setting pulses
`timescale 1ns/100ps
interface ict_div_if;
    logic [3:0] pulse;
    modport src (output pulse);
    modport snk (input pulse);
endinterface

// >>> hw/ict_divider.sv
// free-running dividers producing the four setting pulses
`timescale 1ns/100ps
module ict_divider import ict_pkg::*; #(
    parameter int unsigned PER_0 = PER_10HZ,
    parameter int unsigned PER_1 = PER_20HZ,
    parameter int unsigned PER_2 = PER_50HZ,
    parameter int unsigned PER_3 = PER_100HZ
) (
    input wire logic clk_sys,
    input wire logic rst,
    ict_div_if.src dv
);
    // ======================================================================
    // period lookup
    function automatic int unsigned per_of(input int unsigned idx);
        unique case (idx)
            0: per_of = PER_0;
            1: per_of = PER_1;
            2: per_of = PER_2;
            default: per_of = PER_3;
        endcase
    endfunction

    // refused periods stop elaboration instead of producing no pulse
    if (PER_0 < 2 || PER_1 < 2 || PER_2 < 2 || PER_3 < 2) begin : g_bad_per
        $error("ict_divider: each period needs at least two cycles");
    end

    // ======================================================================
    // dividers: all start together, so phase offset is zero
    // never restarted by selection changes, only by reset
    genvar g;
    generate
        for (g = 0; g < NUM_PULSES; g++) begin : g_div
            localparam int unsigned P = per_of(g);
            logic [31:0] cnt_q;
            logic pulse_q;
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    cnt_q <= 32'h0;
                end else if (cnt_q == P - 1) begin
                    cnt_q <= 32'h0;
                end else begin
                    cnt_q <= cnt_q + 32'h1;
                end
            end
            // high for the first half; rises together with the wrap
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    pulse_q <= 1'b0;
                end else begin
                    pulse_q <= (cnt_q == P - 1) || (cnt_q < P / 2 - 1);
                end
            end
            assign dv.pulse[g] = pulse_q;
        end
    endgenerate
endmodule

// >>> hw/ict_top.sv
// interval carry timer: dividers, carry flag, backup reset, ahb-lite slave
`timescale 1ns/100ps
module ict_top import ict_pkg::*; #(
    parameter int unsigned PER_10 = PER_10HZ,
    parameter int unsigned PER_20 = PER_20HZ,
    parameter int unsigned PER_50 = PER_50HZ,
    parameter int unsigned PER_100 = PER_100HZ
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic backup_pin,
    input wire logic clock_stop,
    output logic backup_reset
);
    // ======================================================================
    // pulse source
    ict_div_if dv ();

    ict_divider #(
        .PER_0(PER_10),
        .PER_1(PER_20),
        .PER_2(PER_50),
        .PER_3(PER_100)
    ) u_div (
        .clk_sys(clk_sys),
        .rst(rst),
        .dv(dv.src)
    );

    // ======================================================================
    // parameter checks
    // the decode assumes slower pulses have longer periods; a refused
    // set stops elaboration rather than running with swapped pulses
    if (PER_10 < PER_20 || PER_20 < PER_50
        || PER_50 < PER_100) begin : g_bad_order
        $error("ict_top: periods must shrink with rising frequency");
    end

    // ======================================================================
    // selection decode
    function automatic logic pick(input logic [1:0] s, input logic [3:0] p);
        unique case (s)
            SEL_10HZ: pick = p[0];
            SEL_20HZ: pick = p[1];
            SEL_50HZ: pick = p[2];
            SEL_100HZ: pick = p[3];
        endcase
    endfunction

    logic [1:0] interval_select_q;
    logic sel_pulse;
    logic sel_prev_q;
    logic set_evt;

    assign sel_pulse = pick(interval_select_q, dv.pulse);
    // a switch from a low pulse onto a high one looks like a rise and sets the flag
    assign set_evt = sel_pulse && !sel_prev_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sel_prev_q <= 1'b0;
        end else begin
            sel_prev_q <= sel_pulse;
        end
    end

    // ======================================================================
    // bus address phase
    logic acc;
    logic rd_carry;
    logic rd_select;
    logic wr_pend_q;
    logic [9:0] wr_addr_q;

    assign acc = hsel && hready && (htrans == HTRANS_NONSEQ)
        && (hsize == HSIZE_WORD);
    // one decode for both register read hits; upper address bits must be clear
    function automatic logic hit(input logic [31:0] a,
                                 input logic [9:0] off);
        hit = (a[9:0] == off) && (a[31:10] == 22'h0);
    endfunction

    assign rd_carry = acc && !hwrite && hit(haddr, ADDR_CARRY);
    assign rd_select = acc && !hwrite && hit(haddr, ADDR_SELECT);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 10'h0;
        end else begin
            wr_pend_q <= acc && hwrite && (haddr[31:10] == 22'h0);
            wr_addr_q <= haddr[9:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            interval_select_q <= SELECT_RESET;
        end else if (wr_pend_q && wr_addr_q == ADDR_SELECT) begin
            interval_select_q <= {hwdata[INTERVAL_SELECT_HI],
                hwdata[INTERVAL_SELECT_LO]};
        end
    end

    // ======================================================================
    // carry flag and arming
    logic interval_carry_flag_q;
    logic armed_q;
    logic pend_q;
    logic bk_fire;

    // a read in the same cycle keeps the backup reset waiting
    assign bk_fire = pend_q && set_evt && !rd_carry;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            armed_q <= 1'b0;
        end else if (rd_carry || bk_fire) begin
            armed_q <= 1'b1;
        end
    end

    // set wins over the read clear; the read still returns the old value
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            interval_carry_flag_q <= 1'b0;
        end else if (clock_stop || bk_fire) begin
            interval_carry_flag_q <= 1'b1;
        end else if (armed_q && set_evt) begin
            interval_carry_flag_q <= 1'b1;
        end else if (rd_carry) begin
            interval_carry_flag_q <= 1'b0;
        end
    end

    // ======================================================================
    // backup pin
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pend_q <= 1'b0;
        end else if (backup_pin) begin
            // a fresh request beats the clearing fire, so none is lost
            pend_q <= 1'b1;
        end else if (bk_fire) begin
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            backup_reset <= 1'b0;
        end else begin
            backup_reset <= bk_fire;
        end
    end

    // ======================================================================
    // bus answer: zero wait, always okay
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0;
        end else if (rd_carry) begin
            hrdata <= {31'h0, interval_carry_flag_q};
        end else if (rd_select) begin
            hrdata <= {30'h0, interval_select_q};
        end else begin
            hrdata <= 32'h0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end
    end

    // ======================================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_first_read_zero: assert property (
        rd_carry && !armed_q |=> hrdata[CARRY_BIT] == 1'b0)
        else $error("first carry read returned one");

    chk_hold_unarmed: assert property (
        !armed_q && !interval_carry_flag_q && !clock_stop && !bk_fire
        |=> !interval_carry_flag_q)
        else $error("carry flag set before first read");

    chk_backup_align: assert property (
        backup_reset |-> $past(set_evt) && $past(pend_q))
        else $error("backup reset not on a setting moment");

    chk_read_clears: assert property (
        rd_carry && !set_evt && !clock_stop && !bk_fire
        |=> !interval_carry_flag_q)
        else $error("carry read did not clear the flag");

    chk_read_value: assert property (
        rd_carry |=> hrdata == {31'h0, $past(interval_carry_flag_q)})
        else $error("carry read returned wrong word");

    chk_backup_flag: assert property (
        backup_reset |-> interval_carry_flag_q && armed_q)
        else $error("flag not one after backup reset");

    chk_clkstop_flag: assert property (
        clock_stop |=> interval_carry_flag_q)
        else $error("flag not one after clock stop");

    chk_rise_sets: assert property (
        armed_q && set_evt |=> interval_carry_flag_q ##1 1'b1)
        else $error("rising selected pulse did not set flag");

    chk_read_defers: assert property (
        pend_q && set_evt && rd_carry |=> !backup_reset && pend_q)
        else $error("backup reset not deferred by coinciding read");

    chk_sel_zero: assert property (
        interval_select_q == SEL_10HZ |-> sel_pulse == dv.pulse[0])
        else $error("select 00 not on 10 Hz pulse");

    chk_read_arms: assert property (
        rd_carry |=> armed_q)
        else $error("carry read did not arm the flag");

    chk_armed_sticky: assert property (
        armed_q |=> armed_q)
        else $error("arming lost before reset");

    chk_pend_held: assert property (
        pend_q && !bk_fire |=> pend_q)
        else $error("backup request dropped before firing");

    chk_no_stray_backup: assert property (
        !pend_q |=> !backup_reset)
        else $error("backup reset without a request");

    chk_backup_pulse: assert property (
        backup_reset |=> !backup_reset)
        else $error("backup reset wider than one cycle");

    chk_flag_sticky: assert property (
        interval_carry_flag_q && !rd_carry |=> interval_carry_flag_q)
        else $error("carry flag cleared without a read");

    chk_clear_by_read: assert property (
        $fell(interval_carry_flag_q) |-> $past(rd_carry))
        else $error("carry flag fell with no read");

    chk_fire_arms: assert property (
        bk_fire |=> armed_q && interval_carry_flag_q)
        else $error("backup reset left flag or arming clear");

    chk_rdata_upper: assert property (
        rd_carry |=> hrdata[31:1] == 31'h0)
        else $error("carry read upper bits not zero");

    chk_idle_rdata: assert property (
        !rd_carry && !rd_select |=> hrdata == 32'h0)
        else $error("read data not zero outside a read");

    chk_select_read: assert property (
        rd_select |=> hrdata == {30'h0, $past(interval_select_q)})
        else $error("select read returned wrong word");

    chk_select_write: assert property (
        wr_pend_q && wr_addr_q == ADDR_SELECT
        |=> interval_select_q == {$past(hwdata[INTERVAL_SELECT_HI]),
            $past(hwdata[INTERVAL_SELECT_LO])})
        else $error("select write not taken");

    chk_select_held: assert property (
        !(wr_pend_q && wr_addr_q == ADDR_SELECT)
        |=> $stable(interval_select_q))
        else $error("select changed without a write");

    chk_sel_hundred: assert property (
        interval_select_q == SEL_100HZ |-> sel_pulse == dv.pulse[3])
        else $error("select 11 not on 100 Hz pulse");

    cov_read_defer: cover property (pend_q && set_evt && rd_carry);
    cov_clock_stop: cover property (clock_stop);
    cov_backup: cover property (backup_reset);
    cov_read_set: cover property (rd_carry && interval_carry_flag_q);
    cov_sel_change: cover property (
        interval_select_q != $past(interval_select_q) && set_evt);
endmodule

// >>> testbench/tb_top.sv
// self-checking bench for the interval carry timer
`timescale 1ns/100ps
module tb_top import ict_pkg::*;;
    // ======================================================================
    // clock, reset and bus signals
    localparam int unsigned P10 = 40;
    localparam int unsigned P20 = 20;
    localparam int unsigned P50 = 8;
    localparam int unsigned P100 = 4;
    localparam logic [31:0] CAR_A = {22'h0, ADDR_CARRY};
    localparam logic [31:0] SEL_A = {22'h0, ADDR_SELECT};
    localparam logic [31:0] BAD_A = 32'h0000_0040;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic backup_pin = 1'b0;
    logic clock_stop = 1'b0;
    logic backup_reset;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    // one slave, so its own ready is the bus ready
    assign hready = hreadyout;
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;
    // small periods keep the run short; nonincreasing as required
    ict_top #(.PER_10(P10), .PER_20(P20), .PER_50(P50), .PER_100(P100))
    ict_top_inst (
        .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .backup_pin(backup_pin), .clock_stop(clock_stop),
        .backup_reset(backup_reset)
    );
    // ======================================================================
    // shared tasks
    task automatic complete_run;
        if (error_cnt == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic compare(input logic [31:0] seen, input logic [31:0] exp,
                           input string msg);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h want %h", $time, msg,
                     seen, exp);
        end
    endtask
    // single word transfer; data taken at the edge that ends the data phase
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output int at);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        @(posedge clk_sys);
        while (hready !== 1'b1) @(posedge clk_sys);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk_sys);
        while (hready !== 1'b1) @(posedge clk_sys);
        rd = hrdata;
        at = cyc;
        compare({31'h0, hresp}, {31'h0, HRESP_OKAY}, "response");
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp,
                          input string msg);
        logic [31:0] rd;
        int at;
        bus(1'b0, a, 32'h0, rd, at);
        compare(rd, exp, msg);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] wd);
        logic [31:0] rd;
        int at;
        bus(1'b1, a, wd, rd, at);
    endtask
    // ======================================================================
    // scenarios
    task automatic reset_state;
        repeat (100) @(posedge clk_sys);
        rd_chk(CAR_A, 32'h0, "first carry read");
        rd_chk(SEL_A, 32'h0, "select reset");
        rd_chk(BAD_A, 32'h0, "unmapped read");
        wr(BAD_A, 32'hffff_ffff);
        wr(CAR_A, 32'hffff_ffff);
        rd_chk(SEL_A, 32'h0, "select after stray writes");
        repeat (P10 + 5) @(posedge clk_sys);
        rd_chk(CAR_A, 32'h1, "carry set once armed");
        rd_chk(CAR_A, 32'h0, "carry after clearing read");
    endtask
    // polls back to back; the poll spacing of two cycles divides each period
    task automatic period_of(input logic [1:0] code, input int p);
        logic [31:0] rd;
        int at;
        int t0;
        int n;
        wr(SEL_A, {30'h0, code});
        rd_chk(SEL_A, {30'h0, code}, "select readback");
        n = 0;
        t0 = 0;
        while (n < 3) begin
            bus(1'b0, CAR_A, 32'h0, rd, at);
            compare({rd[31:1], 1'b0}, 32'h0, "carry upper bits");
            if (rd[0] === 1'b1) begin
                n++;
                if (n == 2) t0 = at;
            end
        end
        compare(at - t0, p, "carry interval");
    endtask
    task automatic stop_and_backup;
        logic [31:0] rd;
        int at;
        int n;
        wr(SEL_A, {30'h0, SEL_10HZ});
        // the switch may have set the flag; this read only clears it
        bus(1'b0, CAR_A, 32'h0, rd, at);
        compare({rd[31:1], 1'b0}, 32'h0, "carry upper bits");
        @(posedge clk_sys);
        clock_stop <= 1'b1;
        @(posedge clk_sys);
        clock_stop <= 1'b0;
        rd_chk(CAR_A, 32'h1, "carry after clock stop");
        backup_pin <= 1'b1;
        @(posedge clk_sys);
        backup_pin <= 1'b0;
        n = 0;
        while (backup_reset !== 1'b1 && n < 2 * P10) begin
            @(posedge clk_sys);
            n++;
        end
        compare({31'h0, backup_reset}, 32'h1, "backup reset fired");
        @(posedge clk_sys);
        compare({31'h0, backup_reset}, 32'h0, "backup reset width");
        rd_chk(CAR_A, 32'h1, "carry after backup reset");
    endtask
    // ======================================================================
    // main sequence and watchdog
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        reset_state();
        period_of(SEL_10HZ, P10);
        period_of(SEL_20HZ, P20);
        period_of(SEL_50HZ, P50);
        period_of(SEL_100HZ, P100);
        stop_and_backup();
        complete_run();
    end
    // far beyond the few hundred cycles the scenarios need
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        $display("wrong value at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule
